// ==== hw/hsppm_unit.sv ====
// stack pop, product move and port write execution unit with apb registers
//
// The register offsets and register access over APB were chosen for this implementation.
`include "hsppm_map.svh"
`default_nettype none
module hsppm_unit (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output hsppm_pkg::hsppm_dm_wr_s o_dm_wr,
   output hsppm_pkg::hsppm_io_wr_s o_io_wr,
   output logic o_busy
);
   import hsppm_pkg::*;

   hsppm_state_e state;
   logic [15:0] stk [`HSPPM_STACK_DEPTH];
   logic [15:0] aux [8];
   logic [2:0] arp;
   logic [31:0] acc;
   logic [31:0] product_register;
   logic [7:0] cmd_addr;
   hsppm_op_e cmd_op;
   logic cmd_rpt;
   hsppm_loc_e prog_loc;
   hsppm_loc_e oper_loc;
   logic same_blk;
   logic [1:0] pm;
   logic [7:0] rpt_n;
   logic [3:0] wait_p;
   logic [3:0] wait_d;
   logic [3:0] wait_io;
   logic [8:0] dpage;
   logic [15:0] port_addr;
   logic [15:0] src_word;
   logic [2:0] sel;
   logic [15:0] cyc_left;
   logic [15:0] last_cycles;
   logic [15:0] run_cnt;
   logic [7:0] iter_left;
   logic wr_en;
   logic start;
   logic do_it;
   logic pop;
   logic push;
   logic [15:0] eff_addr;
   logic [31:0] next_prdata;
   logic next_pslverr;

   // bit-reversed add or subtract, used for fft-style address walks
   function automatic logic [15:0] rc_step(input logic [15:0] a, input logic [15:0] b, input logic sub);
      logic [15:0] ra;
      logic [15:0] rb;
      logic [15:0] rs;
      logic [15:0] res;
      for (int k = 0; k < 16; k++) begin
         ra[k] = a[15 - k];
         rb[k] = b[15 - k];
      end
      rs = sub ? ra - rb : ra + rb;
      for (int k = 0; k < 16; k++) begin
         res[k] = rs[15 - k];
      end
      return res;
   endfunction

   // cycle count from memory placement, wait states and repeat count
   function automatic logic [15:0] calc_cycles(input hsppm_op_e op, input logic repeat_next, input int nn);
      int p;
      int d;
      int io;
      int r;
      logic pe;
      logic oe;
      logic sh;
      p = int'(wait_p);
      d = int'(wait_d);
      io = int'(wait_io);
      pe = (prog_loc == LOC_EXT);
      oe = (oper_loc == LOC_EXT);
      sh = same_blk && (prog_loc == LOC_SINGLE_ACCESS_RAM) && (oper_loc == LOC_SINGLE_ACCESS_RAM);
      r = 1;
      unique case (op)
         OP_LOAD_PRODUCT, OP_POP_ACC: r = nn + (pe ? p : 0);
         OP_POP_DM: begin
            if (!repeat_next) begin
               r = oe ? (pe ? 4 + d + p : 2 + d) : (pe ? 1 + p : (sh ? 2 : 1));
            end else begin
               r = oe ? (pe ? 2 * nn + 2 + nn * d + p : 2 * nn + nn * d)
                      : (pe ? nn + p : (sh ? nn + 2 : nn));
            end
         end
         OP_IO_WRITE: begin
            if (!repeat_next) begin
               r = oe ? (pe ? 6 + d + io + 2 * p : 3 + d + io)
                      : (pe ? 5 + io + 2 * p : (sh ? 4 + io : 3 + io));
            end else begin
               r = oe ? (pe ? 5 * nn + 1 + nn * d + nn * io + 2 * p : 5 * nn - 2 + nn * d + nn * io)
                      : (pe ? 3 * nn + 3 + nn * io + 2 * p : (sh ? 3 * nn + 1 + nn * io : 3 * nn + nn * io));
            end
         end
      endcase
      return 16'(r);
   endfunction

   // apb decode; a write lands only at the access edge with pready high
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
   assign start = wr_en && (i_paddr == `HSPPM_OFF_CMD) && (state == ST_IDLE);
   assign do_it = (state == ST_RUN) && (iter_left != 8'h00);
   assign pop = do_it && (cmd_op == OP_POP_ACC || cmd_op == OP_POP_DM);
   assign push = wr_en && (i_paddr == `HSPPM_OFF_PUSH);
   assign eff_addr = cmd_addr[`HSPPM_CMD_IND] ? aux[arp] : {dpage, cmd_addr[6:0]};

   // read mux; unmapped offsets answer zero with an error
   always_comb begin
      next_prdata = `HSPPM_RST_WORD32;
      next_pslverr = 1'b0;
      unique case (i_paddr)
         `HSPPM_OFF_CMD: next_prdata = {21'h000000, cmd_rpt, cmd_op, cmd_addr};
         `HSPPM_OFF_CFG: next_prdata = {16'h0000, rpt_n, 1'b0, pm, same_blk, oper_loc, prog_loc};
         `HSPPM_OFF_WAIT: next_prdata = {20'h00000, wait_io, wait_d, wait_p};
         `HSPPM_OFF_PAGE: next_prdata = {port_addr, 7'h00, dpage};
         `HSPPM_OFF_PRODUCT_REGISTER: next_prdata = product_register;
         `HSPPM_OFF_ACC: next_prdata = acc;
         `HSPPM_OFF_PUSH: next_prdata = {16'h0000, stk[0]};
         `HSPPM_OFF_STATUS: next_prdata = {last_cycles, 12'h000, arp, o_busy};
         `HSPPM_OFF_SEL: next_prdata = {29'h00000000, sel};
         `HSPPM_OFF_AUX: next_prdata = {16'h0000, aux[sel]};
         `HSPPM_OFF_SRC: next_prdata = {16'h0000, src_word};
         `HSPPM_OFF_PEEK: next_prdata = {16'h0000, stk[sel]};
         default: next_pslverr = 1'b1;
      endcase
   end

   // answer one cycle after setup so that every bus output comes from a flop
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_prdata <= `HSPPM_RST_WORD32;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_prdata <= (i_psel && !i_penable && !i_pwrite) ? next_prdata : `HSPPM_RST_WORD32;
         o_pslverr <= i_psel && !i_penable && next_pslverr;
      end
   end

   // configuration writes; the command word is refused while busy
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cmd_addr <= 8'h00;
         cmd_op <= OP_LOAD_PRODUCT;
         cmd_rpt <= 1'b0;
         prog_loc <= LOC_ROM;
         oper_loc <= LOC_DUAL_ACCESS_RAM;
         same_blk <= 1'b0;
         pm <= 2'h0;
         rpt_n <= 8'h01;
         wait_p <= 4'h0;
         wait_d <= 4'h0;
         wait_io <= 4'h0;
         dpage <= 9'h000;
         port_addr <= `HSPPM_RST_WORD16;
         src_word <= `HSPPM_RST_WORD16;
         sel <= 3'h0;
         product_register <= `HSPPM_RST_WORD32;
      end else if (wr_en) begin
         unique case (i_paddr)
            `HSPPM_OFF_CMD: begin
               if (state == ST_IDLE) begin
                  cmd_addr <= i_pwdata[7:0];
                  cmd_op <= hsppm_op_e'(i_pwdata[`HSPPM_CMD_OP_LO +: 2]);
                  cmd_rpt <= i_pwdata[`HSPPM_CMD_RPT];
               end
            end
            `HSPPM_OFF_CFG: begin
               prog_loc <= hsppm_loc_e'(i_pwdata[1:0]);
               oper_loc <= hsppm_loc_e'(i_pwdata[3:2]);
               same_blk <= i_pwdata[`HSPPM_CFG_SAME];
               pm <= i_pwdata[`HSPPM_CFG_PM_LO +: 2];
               rpt_n <= i_pwdata[`HSPPM_CFG_N_LO +: 8];
            end
            `HSPPM_OFF_WAIT: begin
               wait_p <= i_pwdata[3:0];
               wait_d <= i_pwdata[7:4];
               wait_io <= i_pwdata[11:8];
            end
            `HSPPM_OFF_PAGE: begin
               dpage <= i_pwdata[8:0];
               port_addr <= i_pwdata[31:16];
            end
            `HSPPM_OFF_PRODUCT_REGISTER: product_register <= i_pwdata;
            `HSPPM_OFF_SEL: sel <= i_pwdata[2:0];
            `HSPPM_OFF_SRC: src_word <= i_pwdata[15:0];
            default: ;
         endcase
      end
   end

   // sequencer: busy for exactly the computed count, one effect per repeat
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= ST_IDLE;
         o_busy <= 1'b0;
         cyc_left <= `HSPPM_RST_WORD16;
         last_cycles <= `HSPPM_RST_WORD16;
         iter_left <= 8'h00;
         run_cnt <= `HSPPM_RST_WORD16;
      end else if (start) begin
         state <= ST_RUN;
         o_busy <= 1'b1;
         cyc_left <= calc_cycles(hsppm_op_e'(i_pwdata[`HSPPM_CMD_OP_LO +: 2]), i_pwdata[`HSPPM_CMD_RPT],
                                 (i_pwdata[`HSPPM_CMD_RPT] && rpt_n != 8'h00) ? int'(rpt_n) : 1);
         last_cycles <= calc_cycles(hsppm_op_e'(i_pwdata[`HSPPM_CMD_OP_LO +: 2]), i_pwdata[`HSPPM_CMD_RPT],
                                    (i_pwdata[`HSPPM_CMD_RPT] && rpt_n != 8'h00) ? int'(rpt_n) : 1);
         iter_left <= (i_pwdata[`HSPPM_CMD_RPT] && rpt_n != 8'h00) ? rpt_n : 8'h01;
         run_cnt <= `HSPPM_RST_WORD16;
      end else if (state == ST_RUN) begin
         run_cnt <= run_cnt + 16'h0001;
         if (iter_left != 8'h00) begin
            iter_left <= iter_left - 8'h01;
         end
         if (cyc_left <= 16'h0001) begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
         end else begin
            cyc_left <= cyc_left - 16'h0001;
         end
      end
   end

   // accumulator; no status flags exist here, so none are touched
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         acc <= `HSPPM_RST_WORD32;
      end else if (do_it && cmd_op == OP_LOAD_PRODUCT) begin
         unique case (pm)
            2'h0: acc <= product_register;
            2'h1: acc <= {product_register[30:0], 1'b0};
            2'h2: acc <= {product_register[27:0], 4'h0};
            2'h3: acc <= 32'($signed(product_register) >>> 6);
         endcase
      end else if (do_it && cmd_op == OP_POP_ACC) begin
         acc <= {16'h0000, stk[0]};
      end
   end

   // eight-entry stack, index 0 is the top; the software push port only feeds it
   for (genvar i = 0; i < `HSPPM_STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge i_mclk) begin
         if (i_rst) begin
            stk[i] <= `HSPPM_RST_WORD16;
         end else if (pop) begin
            // bottom keeps its word, so repeated pops replicate it upward
            stk[i] <= (i == `HSPPM_STACK_DEPTH - 1) ? stk[i] : stk[(i + 1) % `HSPPM_STACK_DEPTH];
         end else if (push) begin
            stk[i] <= (i == 0) ? i_pwdata[15:0] : stk[(i + `HSPPM_STACK_DEPTH - 1) % `HSPPM_STACK_DEPTH];
         end
      end
   end

   // aux registers and pointer; indirect accesses update after use
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         arp <= 3'h0;
         for (int k = 0; k < 8; k++) begin
            aux[k] <= `HSPPM_RST_WORD16;
         end
      end else if (do_it && cmd_addr[`HSPPM_CMD_IND] && (cmd_op == OP_POP_DM || cmd_op == OP_IO_WRITE)) begin
         unique case (cmd_addr[6:4])
            `HSPPM_ARU_DEC: aux[arp] <= aux[arp] - 16'h0001;
            `HSPPM_ARU_INC: aux[arp] <= aux[arp] + 16'h0001;
            `HSPPM_ARU_SUB0: aux[arp] <= aux[arp] - aux[0];
            `HSPPM_ARU_ADD0: aux[arp] <= aux[arp] + aux[0];
            `HSPPM_ARU_RC_SUB: aux[arp] <= rc_step(aux[arp], aux[0], 1'b1);
            `HSPPM_ARU_RC_ADD: aux[arp] <= rc_step(aux[arp], aux[0], 1'b0);
            default: ; // no change, including the unused code 3
         endcase
         if (cmd_addr[3]) begin
            arp <= cmd_addr[2:0];
         end
      end else if (wr_en && i_paddr == `HSPPM_OFF_AUX) begin
         aux[sel] <= i_pwdata[15:0];
      end
   end

   // memory and port write strobes, one cycle per repeat
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_dm_wr <= '0;
         o_io_wr <= '{io_strobe_n: 1'b1, addr: 16'h0000, data: 16'h0000};
      end else begin
         o_dm_wr.we <= do_it && cmd_op == OP_POP_DM;
         o_dm_wr.addr <= eff_addr;
         o_dm_wr.data <= stk[0];
         o_io_wr.io_strobe_n <= !(do_it && cmd_op == OP_IO_WRITE);
         o_io_wr.addr <= port_addr;
         o_io_wr.data <= src_word;
      end
   end

   a_pac_no_shift: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && cmd_op == OP_LOAD_PRODUCT && pm == 2'h0 |=> acc == $past(product_register))
      else $error("product not copied unshifted");
   a_pac_shift_four: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && cmd_op == OP_LOAD_PRODUCT && pm == 2'h2 |=> acc == {$past(product_register[27:0]), 4'h0})
      else $error("product shift by four wrong");
   a_pop_acc_word: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && cmd_op == OP_POP_ACC |=> acc[31:16] == 16'h0000 && acc[15:0] == $past(stk[0]))
      else $error("pop to accumulator wrong");
   a_stack_bottom_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
      pop |=> stk[7] == $past(stk[7]) && stk[6] == $past(stk[7]) && stk[0] == $past(stk[1]))
      else $error("stack did not shift up");
   a_pop_to_data_memory_write_top: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && cmd_op == OP_POP_DM |=> o_dm_wr.we && o_dm_wr.data == $past(stk[0]))
      else $error("pop to memory data wrong");
   a_direct_offset: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && cmd_op == OP_POP_DM && !cmd_addr[7] |=> o_dm_wr.addr == {$past(dpage), $past(cmd_addr[6:0])})
      else $error("direct address wrong");
   a_io_strobe_low: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && cmd_op == OP_IO_WRITE |=> !o_io_wr.io_strobe_n && o_io_wr.addr == $past(port_addr))
      else $error("port write strobe wrong");
   a_busy_length: assert property (@(posedge i_mclk) disable iff (i_rst)
      state == ST_RUN && cyc_left == 16'h0001 |=> !o_busy && run_cnt == last_cycles)
      else $error("busy length differs from cycle count");
   a_pac_single_time: assert property (@(posedge i_mclk) disable iff (i_rst)
      start && i_pwdata[9:8] == 2'h0 && !i_pwdata[10] && prog_loc != LOC_EXT |=> o_busy ##1 !o_busy)
      else $error("single internal load product not one cycle");
   a_product_register_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
      do_it && !(wr_en && i_paddr == `HSPPM_OFF_PRODUCT_REGISTER) |=> product_register == $past(product_register))
      else $error("product register changed");
endmodule
`default_nettype wire

// ==== hw/hsppm_map.svh ====
// offsets, field positions, reset values and codes of the stack pop and product move unit
`ifndef HSPPM_MAP_SVH
`define HSPPM_MAP_SVH
`define HSPPM_OFF_CMD 12'h000
`define HSPPM_OFF_CFG 12'h004
`define HSPPM_OFF_WAIT 12'h008
`define HSPPM_OFF_PAGE 12'h00C
`define HSPPM_OFF_PRODUCT_REGISTER 12'h010
`define HSPPM_OFF_ACC 12'h014
`define HSPPM_OFF_PUSH 12'h018
`define HSPPM_OFF_STATUS 12'h01C
`define HSPPM_OFF_SEL 12'h020
`define HSPPM_OFF_AUX 12'h024
`define HSPPM_OFF_SRC 12'h028
`define HSPPM_OFF_PEEK 12'h02C
`define HSPPM_CMD_IND 7
`define HSPPM_CMD_OP_LO 8
`define HSPPM_CMD_RPT 10
`define HSPPM_CFG_SAME 4
`define HSPPM_CFG_PM_LO 5
`define HSPPM_CFG_N_LO 8
`define HSPPM_ARU_NONE 3'h0
`define HSPPM_ARU_DEC 3'h1
`define HSPPM_ARU_INC 3'h2
`define HSPPM_ARU_RC_SUB 3'h4
`define HSPPM_ARU_SUB0 3'h5
`define HSPPM_ARU_ADD0 3'h6
`define HSPPM_ARU_RC_ADD 3'h7
`define HSPPM_RST_WORD16 16'h0000
`define HSPPM_RST_WORD32 32'h0000_0000
`define HSPPM_STACK_DEPTH 8
`endif

// ==== hw/hsppm_pkg.sv ====
// types shared by the stack pop and product move unit
`default_nettype none
package hsppm_pkg;
   typedef enum logic [1:0] {OP_LOAD_PRODUCT, OP_POP_ACC, OP_POP_DM, OP_IO_WRITE} hsppm_op_e;
   typedef enum logic [1:0] {LOC_ROM, LOC_DUAL_ACCESS_RAM, LOC_SINGLE_ACCESS_RAM, LOC_EXT} hsppm_loc_e;
   typedef enum {ST_IDLE, ST_RUN} hsppm_state_e;
   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] data;
   } hsppm_dm_wr_s;
   typedef struct packed {
      logic io_strobe_n;
      logic [15:0] addr;
      logic [15:0] data;
   } hsppm_io_wr_s;
endpackage
`default_nettype wire

// ==== verif/tb_hsppm_unit.sv ====
// self-checking testbench of the stack pop and product move unit
`include "hsppm_map.svh"
`default_nettype none
module tb_hsppm_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import hsppm_pkg::*;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, busy, erv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, seed;
   hsppm_dm_wr_s dm;
   hsppm_io_wr_s io;
   logic [15:0] stk [8];
   logic [15:0] dq[$], aq[$], iq[$], jq[$];
   int bad_count, tests_run, run_len;

   hsppm_unit uut (.i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_dm_wr(dm), .o_io_wr(io), .o_busy(busy));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // collect busy cycles and output pulses; pulses trail busy by one cycle
   always @(posedge mclk) begin
      if (busy === 1'b1) run_len = run_len + 1;
      if (dm.we === 1'b1) begin
         dq.push_back(dm.data);
         aq.push_back(dm.addr);
      end
      if (io.io_strobe_n === 1'b0) begin
         iq.push_back(io.data);
         jq.push_back(io.addr);
      end
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   function automatic logic [31:0] shp(input logic [31:0] x, input logic [1:0] m);
      case (m)
         2'h0: return x;
         2'h1: return x << 1;
         2'h2: return x << 4;
         default: return $signed(x) >>> 6;
      endcase
   endfunction

   function automatic logic [15:0] rv(input logic [15:0] x);
      logic [15:0] y;
      for (int k = 0; k < 16; k++) y[k] = x[15 - k];
      return y;
   endfunction

   // address register after an indirect access; x is index register zero
   function automatic logic [15:0] upd(input int c, input logic [15:0] a, input logic [15:0] x);
      case (c)
         1: return a - 16'h1;
         2: return a + 16'h1;
         4: return rv(rv(a) - rv(x));
         5: return a - x;
         6: return a + x;
         7: return rv(rv(a) + rv(x));
         default: return a;
      endcase
   endfunction

   // expected busy length from op, program and operand places, waits and count
   function automatic int cyc(int op, int pl, int ol, int sm, int rp, int n, int p, int d, int io);
      bit pe, oe, sb;
      pe = (pl == 3);
      oe = (ol == 3);
      sb = (pl == 2 && ol == 2 && sm == 1);
      if (rp == 0) n = 1;
      case (op)
         0, 1: return n + (pe ? p : 0);
         2: if (rp == 0) return oe ? (pe ? 4+d+p : 2+d) : (pe ? 1+p : (sb ? 2 : 1));
            else return oe ? (pe ? 2*n+2+n*d+p : 2*n+n*d) : (pe ? n+p : (sb ? n+2 : n));
         default: if (rp == 0) return oe ? (pe ? 6+d+io+2*p : 3+d+io) : (pe ? 5+io+2*p : (sb ? 4+io : 3+io));
            else return oe ? (pe ? 5*n+1+n*d+n*io+2*p : 5*n-2+n*d+n*io)
               : (pe ? 3*n+3+n*io+2*p : (sb ? 3*n+1+n*io : 3*n+n*io));
      endcase
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rdv = prdata;
      erv = pslverr;
      chk("pready", {31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rdv, exp);
   endtask

   task automatic push(input logic [15:0] v);
      apb(1'b1, `HSPPM_OFF_PUSH, {16'h0, v});
      for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
      stk[0] = v;
   endtask

   function automatic logic [15:0] pop_m();
      logic [15:0] v;
      v = stk[0];
      for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
      return v;
   endfunction

   // start an instruction and measure how long busy stays up
   task automatic run(input logic [31:0] cmd, input int exp_len);
      int k;
      dq.delete();
      aq.delete();
      iq.delete();
      jq.delete();
      run_len = 0;
      apb(1'b1, `HSPPM_OFF_CMD, cmd);
      k = 0;
      while (busy === 1'b1 && k < 2000) begin
         @(posedge mclk);
         k++;
      end
      @(posedge mclk);
      chk("busy length", run_len, exp_len);
      // the status word keeps the count of the last start and shows idle
      apb(1'b0, `HSPPM_OFF_STATUS, 32'h0);
      chk("last cycles", {16'h0, rdv[31:16]}, exp_len);
      chk("busy flag", {31'h0, rdv[0]}, 32'h0);
   endtask

   task automatic peek_all();
      for (int i = 0; i < `HSPPM_STACK_DEPTH; i++) begin
         apb(1'b1, `HSPPM_OFF_SEL, i);
         rdchk("stack entry", `HSPPM_OFF_PEEK, {16'h0, stk[i]});
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // cut a hang short; the whole sequence needs far fewer cycles
   initial begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      wrap_up();
   end

   initial begin
      int op, pl, ol, sm, rp, n, p, d, iw, pm, cur;
      logic [31:0] r, w, pv;
      logic [15:0] v, k0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      seed = 32'h4;
      bad_count = 0;
      tests_run = 0;
      run_len = 0;
      foreach (stk[i]) stk[i] = 16'h0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      peek_all();
      apb(1'b0, 12'h030, 32'h0);
      chk("unmapped error", {31'h0, erv}, 32'h1);
      $display("test reset and map done");
      // every shift mode, product forced negative for the arithmetic shift
      for (int m = 0; m < 4; m++) begin
         pv = rnd();
         pv[31] = 1'b1;
         apb(1'b1, `HSPPM_OFF_PRODUCT_REGISTER, pv);
         apb(1'b1, `HSPPM_OFF_CFG, {25'h0, m[1:0], 5'h0});
         run(32'h0, 1);
         rdchk("acc product", `HSPPM_OFF_ACC, shp(pv, m[1:0]));
         rdchk("product kept", `HSPPM_OFF_PRODUCT_REGISTER, pv);
      end
      $display("test shift modes done");
      // random mix; first four use the shared single-access block
      for (int t = 0; t < 40; t++) begin
         r = rnd();
         w = rnd();
         op = r[1:0];
         pl = r[3:2];
         ol = (r[5:4] == 2'h0) ? 1 : r[5:4];
         sm = r[6];
         rp = r[7];
         if (t < 4) begin
            op = t;
            pl = 2;
            ol = 2;
            sm = 1;
         end
         n = (rp == 1) ? 1 + r[9:8] : 1;
         pm = r[12:11];
         p = w[3:0];
         d = w[7:4];
         iw = w[11:8];
         pv = rnd();
         push(pv[15:0]);
         pv = rnd();
         apb(1'b1, `HSPPM_OFF_PRODUCT_REGISTER, pv);
         apb(1'b1, `HSPPM_OFF_SRC, {16'h0, pv[15:0]});
         apb(1'b1, `HSPPM_OFF_PAGE, w);
         apb(1'b1, `HSPPM_OFF_WAIT, {20'h0, w[11:0]});
         apb(1'b1, `HSPPM_OFF_CFG, {16'h0, n[7:0], 1'b0, pm[1:0], sm[0], ol[1:0], pl[1:0]});
         run({21'h0, rp[0], op[1:0], 1'b0, r[22:16]},
             cyc(op, pl, ol, sm, rp, n, p, d, iw));
         if (op == 0) rdchk("acc product", `HSPPM_OFF_ACC, shp(pv, pm[1:0]));
         if (op == 1) begin
            for (int i = 0; i < n; i++) v = pop_m();
            rdchk("acc pop", `HSPPM_OFF_ACC, {16'h0, v});
         end
         if (op == 2) begin
            chk("memory writes", dq.size(), n);
            for (int i = 0; i < n; i++) begin
               chk("memory data", dq[i], pop_m());
               chk("memory address", aq[i], {w[8:0], r[22:16]});
            end
         end
         if (op == 3) begin
            chk("port writes", iq.size(), n);
            for (int i = 0; i < n; i++) begin
               chk("port data", iq[i], pv[15:0]);
               chk("port address", jq[i], w[31:16]);
            end
         end
      end
      peek_all();
      $display("test random mix done");
      // every indirect update code, each naming register c as the next current register
      apb(1'b1, `HSPPM_OFF_WAIT, 32'h0);
      apb(1'b1, `HSPPM_OFF_CFG, 32'h4);
      cur = 0;
      for (int c = 0; c < 8; c++) begin
         r = rnd();
         v = r[15:0];
         r = rnd();
         k0 = r[15:0];
         apb(1'b1, `HSPPM_OFF_SEL, 32'h0);
         apb(1'b1, `HSPPM_OFF_AUX, {16'h0, k0});
         apb(1'b1, `HSPPM_OFF_SEL, cur);
         apb(1'b1, `HSPPM_OFF_AUX, {16'h0, v});
         if (cur == 0) k0 = v;
         run({22'h0, 2'h2, 1'b1, c[2:0], 1'b1, c[2:0]}, 1);
         chk("indirect address", aq[0], v);
         chk("indirect data", dq[0], pop_m());
         rdchk("aux update", `HSPPM_OFF_AUX, {16'h0, upd(c, v, k0)});
         apb(1'b0, `HSPPM_OFF_STATUS, 32'h0);
         chk("next aux", rdv[3:1], c);
         cur = c;
      end
      // an indirect port write steps the current aux register as well
      apb(1'b1, `HSPPM_OFF_SEL, cur);
      apb(1'b1, `HSPPM_OFF_AUX, {16'h0, v});
      run(32'h3A0, 3);
      chk("port writes", iq.size(), 32'h1);
      rdchk("aux update", `HSPPM_OFF_AUX, {16'h0, v + 16'h1});
      $display("test indirect codes done");
      // nine pops with no push leave every level holding the bottom word
      apb(1'b1, `HSPPM_OFF_CFG, 32'h900);
      run(32'h500, 9);
      for (int i = 0; i < 9; i++) v = pop_m();
      rdchk("acc pop", `HSPPM_OFF_ACC, {16'h0, v});
      peek_all();
      $display("test underflow done");
      wrap_up();
   end
endmodule
`default_nettype wire
